/* rtl/fis_pkg.sv */
/*
  Shared constants for the two-wire serial memory slave: memory geometry,
  slave address fields, master code prefix, reset values and the one-hot
  link state encoding.
  Assumes nothing of its surroundings; imported by the slave module.
*/
package fis_pkg;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int          FIS_MEM_DEPTH  = 32768;
  localparam int          FIS_ADDR_W     = 15;
  localparam logic [14:0] FIS_ADDR_RST   = 15'h0000;

  // ****************************************
  // Slave address byte fields
  // ****************************************
  localparam int          FIS_TYPE_MSB   = 7;
  localparam int          FIS_TYPE_LSB   = 4;
  localparam logic [3:0]  FIS_DEV_TYPE   = 4'hA;
  localparam int          FIS_SEL_MSB    = 3;
  localparam int          FIS_SEL_LSB    = 1;
  localparam int          FIS_RW_BIT     = 0;
  localparam int          FIS_MCODE_LSB  = 3;
  localparam logic [4:0]  FIS_MCODE_TOP  = 5'h01;

  // ****************************************
  // Bit counting and reset values
  // ****************************************
  localparam logic [3:0]  FIS_BYTE_BITS  = 4'h8;
  localparam logic [3:0]  FIS_CNT_RST    = 4'h0;
  localparam logic [7:0]  FIS_BYTE_RST   = 8'h00;
  localparam logic [6:0]  FIS_AHI_RST    = 7'h00;

  // ****************************************
  // Link state encoding
  // ****************************************
  typedef enum logic [7:0] {
    FIS_ST_IDLE = 8'h01,
    FIS_ST_DEV  = 8'h02,
    FIS_ST_ADH  = 8'h04,
    FIS_ST_ADL  = 8'h08,
    FIS_ST_WR   = 8'h10,
    FIS_ST_RD   = 8'h20,
    FIS_ST_ACKO = 8'h40,
    FIS_ST_ACKI = 8'h80
  } fis_state_t;

endpackage

/* rtl/fis_slave.sv */
/*
  Two-wire serial slave in front of a byte-wide memory held in flip-flops. The link logic runs on the
  free-running sampling clock link_clk, into which the bus lines and device select pins are synchronised;
  completed memory writes, the high-speed flag and the busy level cross to core_clk.
  Assumes an external pull-up on data and a master making the serial clock; sda_oe pulls the line to sda_out.
*/
`timescale 1ns/1ps

module fis_slave #(
  parameter int DEPTH  = fis_pkg::FIS_MEM_DEPTH,
  parameter int ADDR_W = fis_pkg::FIS_ADDR_W
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              link_clk,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [2:0]        device_select_pins,
  output logic                   hs_mode,
  output logic                   link_busy,
  output logic                   wr_event,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_data
);
  import fis_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Address wrap relies on the counter overflowing exactly at the last byte
  if (ADDR_W != 15 || DEPTH != (1 << ADDR_W))
  begin : g_bad_geometry
    $error("fis_slave: DEPTH must equal 2**ADDR_W and ADDR_W must be 15");
  end

  // ****************************************
  // Link domain reset release
  // ****************************************
  logic [1:0]          lrst_sync_r;
  logic                lrst_n;

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
      lrst_sync_r <= 2'h0;
    else
      lrst_sync_r <= {lrst_sync_r[0], 1'b1};
  end

  assign lrst_n = lrst_sync_r[1];

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [1:0]          scl_sync_r;
  logic [1:0]          sda_sync_r;
  logic                scl_q_r;
  logic                sda_q_r;
  logic [2:0]          sel_meta_r;
  logic [2:0]          sel_r;
  logic                scl_s;
  logic                sda_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                bus_start;
  logic                bus_stop;

  always_ff @(posedge link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      sel_meta_r <= 3'h0;
      sel_r      <= 3'h0;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_q_r    <= scl_sync_r[1];
      sda_q_r    <= sda_sync_r[1];
      sel_meta_r <= device_select_pins;
      sel_r      <= sel_meta_r;
    end
  end

  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  // Data moving while the clock stays high is a bus condition, not a bit
  assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ****************************************
  // Byte decode
  // ****************************************
  fis_state_t          state_r;
  fis_state_t          after_r;
  fis_state_t          after_nxt;
  logic [3:0]          bit_cnt_r;
  logic [7:0]          shift_r;
  logic [7:0]          tx_r;
  logic                ack_seen_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [6:0]          addr_hi_r;
  logic                hs_r;
  logic [7:0]          mem [DEPTH];
  logic [7:0]          mem_q;
  logic                rx_state;
  logic                byte_end;
  logic                rd_end;
  logic                dev_match;
  logic                is_mcode;
  logic                ack_now;

  function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] sel);
    addr_hit = (b[FIS_TYPE_MSB:FIS_TYPE_LSB] == FIS_DEV_TYPE) &&
               (b[FIS_SEL_MSB:FIS_SEL_LSB] == sel);
  endfunction

  assign mem_q     = mem[addr_r];
  assign rx_state  = (state_r == FIS_ST_DEV) || (state_r == FIS_ST_ADH) ||
                     (state_r == FIS_ST_ADL) || (state_r == FIS_ST_WR);
  // Byte is complete at the falling edge that follows the eighth rising edge
  assign byte_end  = rx_state & scl_fall & (bit_cnt_r == FIS_BYTE_BITS);
  assign rd_end    = (state_r == FIS_ST_RD) & scl_fall & (bit_cnt_r == FIS_BYTE_BITS);
  assign dev_match = addr_hit(shift_r, sel_r);
  assign is_mcode  = (shift_r[7:FIS_MCODE_LSB] == FIS_MCODE_TOP);

  always_comb
  begin
    ack_now   = 1'b1;
    after_nxt = FIS_ST_IDLE;
    case (state_r)
      FIS_ST_DEV:
      begin
        ack_now   = dev_match;
        after_nxt = shift_r[FIS_RW_BIT] ? FIS_ST_RD : FIS_ST_ADH;
      end
      FIS_ST_ADH:
        after_nxt = FIS_ST_ADL;
      FIS_ST_ADL:
        after_nxt = FIS_ST_WR;
      FIS_ST_WR:
        after_nxt = FIS_ST_WR;
      default:
      begin
        ack_now   = 1'b0;
        after_nxt = FIS_ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Link state machine and data line
  // ****************************************
  // The pin is only ever pulled low; the clock line is never driven
  assign sda_out = 1'b0;

  always_ff @(posedge link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      state_r    <= FIS_ST_IDLE;
      after_r    <= FIS_ST_IDLE;
      bit_cnt_r  <= FIS_CNT_RST;
      shift_r    <= FIS_BYTE_RST;
      tx_r       <= FIS_BYTE_RST;
      ack_seen_r <= 1'b0;
      sda_oe     <= 1'b0;
    end
    else if (bus_start || bus_stop)
    begin
      state_r   <= bus_start ? FIS_ST_DEV : FIS_ST_IDLE;
      bit_cnt_r <= FIS_CNT_RST;
      sda_oe    <= 1'b0;
    end
    else
    begin
      case (state_r)
        FIS_ST_DEV, FIS_ST_ADH, FIS_ST_ADL, FIS_ST_WR:
        begin
          if (scl_rise && bit_cnt_r != FIS_BYTE_BITS)
          begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (byte_end)
          begin
            bit_cnt_r <= FIS_CNT_RST;
            after_r   <= after_nxt;
            if (ack_now)
            begin
              sda_oe  <= 1'b1;
              state_r <= FIS_ST_ACKO;
            end
            else
              state_r <= FIS_ST_IDLE;
          end
        end
        FIS_ST_ACKO:
        begin
          if (scl_fall)
          begin
            state_r   <= after_r;
            bit_cnt_r <= FIS_CNT_RST;
            sda_oe    <= (after_r == FIS_ST_RD) & ~mem_q[7];
            tx_r      <= {mem_q[6:0], 1'b0};
          end
        end
        FIS_ST_RD:
        begin
          if (scl_rise && bit_cnt_r != FIS_BYTE_BITS)
            bit_cnt_r <= bit_cnt_r + 4'h1;
          if (rd_end)
          begin
            sda_oe     <= 1'b0;
            bit_cnt_r  <= FIS_CNT_RST;
            ack_seen_r <= 1'b0;
            state_r    <= FIS_ST_ACKI;
          end
          else if (scl_fall)
          begin
            sda_oe <= ~tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
          end
        end
        FIS_ST_ACKI:
        begin
          if (scl_rise)
          begin
            ack_seen_r <= ~sda_s;
            bit_cnt_r  <= 4'h1;
          end
          if (scl_fall && bit_cnt_r == 4'h1)
          begin
            bit_cnt_r <= FIS_CNT_RST;
            if (ack_seen_r)
            begin
              state_r <= FIS_ST_RD;
              sda_oe  <= ~mem_q[7];
              tx_r    <= {mem_q[6:0], 1'b0};
            end
            else
              state_r <= FIS_ST_IDLE;
          end
        end
        default:
        begin
          state_r <= FIS_ST_IDLE;
          sda_oe  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Address latch
  // ****************************************
  // Not cleared by bus conditions: a read after a fresh START continues here
  always_ff @(posedge link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      addr_r    <= FIS_ADDR_RST;
      addr_hi_r <= FIS_AHI_RST;
    end
    else if (byte_end && state_r == FIS_ST_ADH)
      addr_hi_r <= shift_r[6:0];
    else if (byte_end && state_r == FIS_ST_ADL)
      addr_r <= {addr_hi_r, shift_r};
    else if ((byte_end && state_r == FIS_ST_WR) || rd_end)
      addr_r <= addr_r + 1'b1;
  end

  // ****************************************
  // Memory array
  // ****************************************
  // Written at the close of the eighth bit, so stored before the acknowledge and any later transfer
  always_ff @(posedge link_clk)
  begin
    if (byte_end && state_r == FIS_ST_WR && !bus_start && !bus_stop)
      mem[addr_r] <= shift_r;
  end

  // ****************************************
  // High-speed mode flag
  // ****************************************
  always_ff @(posedge link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
      hs_r <= 1'b0;
    else if (bus_stop)
      hs_r <= 1'b0;
    else if (byte_end && state_r == FIS_ST_DEV && is_mcode)
      hs_r <= 1'b1;
  end

  // ****************************************
  // Write notification, link side
  // ****************************************
  logic                wr_tog_r;
  logic [ADDR_W-1:0]   wr_addr_l_r;
  logic [7:0]          wr_data_l_r;
  logic                busy_l_r;

  // Held words stay put for at least nine bus clocks, far longer than the
  // toggle needs to cross, so they are safe to sample on the other side
  always_ff @(posedge link_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      wr_tog_r    <= 1'b0;
      wr_addr_l_r <= FIS_ADDR_RST;
      wr_data_l_r <= FIS_BYTE_RST;
      busy_l_r    <= 1'b0;
    end
    else
    begin
      busy_l_r <= (state_r != FIS_ST_IDLE);
      if (byte_end && state_r == FIS_ST_WR && !bus_start && !bus_stop)
      begin
        wr_tog_r    <= ~wr_tog_r;
        wr_addr_l_r <= addr_r;
        wr_data_l_r <= shift_r;
      end
    end
  end

  // ****************************************
  // Core side crossing
  // ****************************************
  logic [1:0]          tog_sync_r;
  logic                tog_q_r;
  logic [1:0]          hs_sync_r;
  logic [1:0]          busy_sync_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tog_sync_r  <= 2'h0;
      tog_q_r     <= 1'b0;
      hs_sync_r   <= 2'h0;
      busy_sync_r <= 2'h0;
      wr_event    <= 1'b0;
      wr_addr     <= FIS_ADDR_RST;
      wr_data     <= FIS_BYTE_RST;
    end
    else
    begin
      tog_sync_r  <= {tog_sync_r[0], wr_tog_r};
      tog_q_r     <= tog_sync_r[1];
      hs_sync_r   <= {hs_sync_r[0], hs_r};
      busy_sync_r <= {busy_sync_r[0], busy_l_r};
      wr_event    <= tog_sync_r[1] ^ tog_q_r;
      if (tog_sync_r[1] ^ tog_q_r)
      begin
        wr_addr <= wr_addr_l_r;
        wr_data <= wr_data_l_r;
      end
    end
  end

  assign hs_mode   = hs_sync_r[1];
  assign link_busy = busy_sync_r[1];

endmodule

/* test/fis_slave_properties.sv */
/*
  Concurrent checks on the ports of the two-wire memory slave.
  Assumes it is bound into fis_slave; link checks on link_clk, core checks on core_clk.
*/
`timescale 1ns/1ps

module fis_slave_properties
  import fis_pkg::*;
#(
  parameter int DEPTH  = FIS_MEM_DEPTH,
  parameter int ADDR_W = FIS_ADDR_W
) (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              link_clk,
  input wire logic              scl_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic              hs_mode,
  input wire logic              link_busy,
  input wire logic              wr_event,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [7:0]        wr_data
);
  // ****************
  // Link side
  // ****************
  // Slot held well past the sync delay
  sequence oe_slot;
    sda_oe [*4];
  endsequence

  sda_low_a: assert property (@(posedge link_clk) disable iff (!nrst) sda_out == 1'b0)
    else $error("data line driven high");
  ack_rise_a: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data pulled low while clock high");
  oe_fall_a: assert property (@(posedge link_clk) disable iff (!nrst)
    $fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  oe_hold_a: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(sda_oe) |-> oe_slot)
    else $error("driven slot too short");

  // ****************
  // Core side
  // ****************
  wr_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_event |=> !wr_event)
    else $error("write notice longer than one cycle");
  wr_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !wr_event |-> $stable(wr_addr) && $stable(wr_data))
    else $error("write address or data moved");
  wr_busy_a: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_event |-> link_busy && (int'(wr_addr) < DEPTH))
    else $error("write outside a transfer");
  hs_exit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(hs_mode) |-> ##[0:2] (!link_busy && !hs_mode))
    else $error("high speed left while busy");
endmodule

bind fis_slave fis_slave_properties #(
  .DEPTH(DEPTH),
  .ADDR_W(ADDR_W)
) u_fis_props (
  .core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .hs_mode(hs_mode), .link_busy(link_busy),
  .wr_event(wr_event), .wr_addr(wr_addr), .wr_data(wr_data)
);

/* test/fis_bus_master.sv */
/*
  Behavioural bus master: makes the serial clock and drives the data line
  open-drain style (1 = released). Assumes the bench resolves the wired-AND.
*/
`timescale 1ns/1ps

module fis_bus_master (
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  // ****************
  // Bus timing
  // ****************
  // Quarter clock period; 800 ns bit keeps the slave's sampler comfortable
  localparam int QP = 200;

  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ****************
  // Conditions and bits
  // ****************
  task automatic start();
    sda_drv = 1'b1;
    #QP;
    scl = 1'b1;
    #QP;
    sda_drv = 1'b0;
    #QP;
    scl = 1'b0;
  endtask

  // Only called while the master owns the line
  task automatic stop();
    #QP;
    sda_drv = 1'b0;
    #QP;
    scl = 1'b1;
    #QP;
    sda_drv = 1'b1;
    #QP;
  endtask

  task automatic bit_io(input logic b, output logic r);
    #QP;
    sda_drv = b;
    #QP;
    scl = 1'b1;
    #QP;
    r = sda_in;
    #QP;
    scl = 1'b0;
  endtask

  task automatic send_bits(input logic [7:0] d, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--)
      bit_io(d[i], r);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    send_bits(d, 8);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

/* test/tb.sv */
/*
  Self-checking bench for the two-wire memory slave.
  Assumes fis_slave, fis_bus_master and the bound checker are compiled before it.
*/
`timescale 1ns/1ps

module tb;
  import fis_pkg::*;
  logic        core_clk, link_clk, nrst, scl, sda_drv, sda_in;
  logic        sda_out, sda_oe, hs_mode, link_busy, wr_event, ack, r;
  logic [2:0]  dsel;
  logic [14:0] wr_addr, cur, base;
  logic [7:0]  wr_data;
  logic [7:0]  mem [FIS_MEM_DEPTH];
  logic [22:0] exp_q [$];
  int          errors, samples_checked, cyc;

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // Open-drain line with pull-up
  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

  fis_slave dut (
    .core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(dsel), .hs_mode(hs_mode),
    .link_busy(link_busy), .wr_event(wr_event), .wr_addr(wr_addr), .wr_data(wr_data)
  );
  fis_bus_master m (.sda_in(sda_in), .scl(scl), .sda_drv(sda_drv));

  // ****************
  // Checking
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge core_clk)
    if (nrst === 1'b1 && wr_event === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0, "unexpected write");
      else
        check({wr_addr, wr_data}, exp_q.pop_front(), "write");
    end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
    end
  end

  // ****************
  // Transfers
  // ****************
  task automatic do_reset();
    nrst = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check({sda_oe, hs_mode, link_busy, wr_event, wr_addr, wr_data}, 32'h0, "reset state");
  endtask

  task automatic wr_xfer(input logic [14:0] a, input int n);
    logic [7:0] v;
    cur = a;
    m.start();
    m.put_byte({FIS_DEV_TYPE, dsel, 1'b0}, ack);
    check(ack, 32'h1, "select ack");
    m.put_byte({1'($urandom_range(1, 0)), a[14:8]}, ack);
    check(ack, 32'h1, "addr hi ack");
    m.put_byte(a[7:0], ack);
    check(ack, 32'h1, "addr lo ack");
    repeat (n)
    begin
      v = 8'($urandom);
      mem[cur] = v;
      exp_q.push_back({cur, v});
      m.put_byte(v, ack);
      check(ack, 32'h1, "data ack");
      cur = cur + 15'h0001;
    end
  endtask

  task automatic rd_xfer(input int n);
    logic [7:0] v;
    m.start();
    m.put_byte({FIS_DEV_TYPE, dsel, 1'b1}, ack);
    check(ack, 32'h1, "read select ack");
    for (int i = 0; i < n; i++)
    begin
      m.get_byte(i < n - 1, v);
      check(v, mem[cur], "read data");
      cur = cur + 15'h0001;
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    nrst = 1'b0;
    dsel = 3'h0;
    errors = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(68));
    do_reset();
    dsel = 3'($urandom_range(7, 0));
    base = 15'($urandom);
    wr_xfer(base, 4);
    m.stop();
    wr_xfer(15'h7FFE, 3);
    m.stop();
    wr_xfer(base, 0);
    rd_xfer(4);
    m.stop();
    wr_xfer(15'h7FFF, 0);
    rd_xfer(2);
    m.bit_io(1'b1, r);
    check(r, 32'h1, "released after nack");
    m.stop();
    for (int s = 0; s < 8; s++)
    begin
      m.start();
      m.put_byte({FIS_DEV_TYPE, 3'(s), 1'b0}, ack);
      check(ack, 3'(s) == dsel, "select match");
      m.stop();
    end
    m.start();
    m.put_byte({4'h5, dsel, 1'b0}, ack);
    check(ack, 32'h0, "type mismatch");
    m.put_byte(8'h00, ack);
    check(ack, 32'h0, "byte after nack");
    m.stop();
    m.start();
    m.put_byte({FIS_MCODE_TOP, 3'($urandom_range(7, 0))}, ack);
    check(ack, 32'h0, "master code");
    repeat (4) @(posedge core_clk);
    #1;
    check(hs_mode, 32'h1, "hs entry");
    wr_xfer(base, 1);
    check(hs_mode, 32'h1, "hs kept");
    check(link_busy, 32'h1, "busy in transfer");
    m.stop();
    repeat (4) @(posedge core_clk);
    #1;
    check(hs_mode, 32'h0, "hs exit");
    check(link_busy, 32'h0, "idle after stop");
    // Partial bytes must be dropped, latch kept
    wr_xfer(base, 0);
    m.send_bits(8'hA5, 5);
    m.stop();
    wr_xfer(base, 0);
    m.send_bits(8'h5A, 7);
    rd_xfer(1);
    m.stop();
    do_reset();
    cur = FIS_ADDR_RST;
    rd_xfer(1);
    m.stop();
    repeat (6) @(posedge core_clk);
    check(exp_q.size(), 32'h0, "pending writes");
    wrap_up();
  end
endmodule
